// File: design/rdi_cfg.svh
// offsets, field positions, reset values and timing counts of the config slave
`ifndef RDI_CFG_SVH
`define RDI_CFG_SVH

// fixed upper address bits, low three bits come from straps
`define RDI_ADDR_FIXED      4'ha

// register offsets
`define RDI_OFS_REV_VENDOR  5'h00
`define RDI_OFS_DEVICE_ID   5'h01
`define RDI_OFS_BYTE_COUNT  5'h02
`define RDI_OFS_MODE        5'h03
`define RDI_OFS_POWER_DOWN  5'h04
`define RDI_OFS_LANE_FIRST  5'h05
`define RDI_OFS_LANE_LAST   5'h08
`define RDI_OFS_RSVD_NINE   5'h09
`define RDI_OFS_PAIR_B_FEAT 5'h0a
`define RDI_OFS_PAIR_A_FEAT 5'h0b
`define RDI_OFS_THRESHOLD   5'h0c
`define RDI_OFS_LAST        5'h0c

// reset values
`define RDI_RST_BYTE_COUNT  8'h20
`define RDI_RST_MODE        8'h00
`define RDI_RST_POWER_DOWN  8'h0d
`define RDI_RST_LANE        8'h03
`define RDI_RST_RSVD_NINE   8'h60
`define RDI_RST_FEATURE     8'hfc
`define RDI_RST_THRESHOLD   8'h58
`define RDI_DUMMY_BYTE      8'hff

// field positions
`define RDI_MODE_SEL_HI     7
`define RDI_MODE_SEL_LO     4
`define RDI_DET_DIS_BIT     2
`define RDI_PD_LANE_A_RX    7
`define RDI_PD_LANE_A_TX    6
`define RDI_PD_LANE_B_TX    5
`define RDI_PD_LANE_B_RX    4
`define RDI_PD_LOW_BITS     4'hd
`define RDI_HP_POL_BIT      1
`define RDI_EQ_HI           7
`define RDI_EQ_LO           4
`define RDI_FG_HI           3
`define RDI_FG_LO           2
`define RDI_SW_HI           1
`define RDI_SW_LO           0
`define RDI_VTH_HI          7
`define RDI_VTH_LO          6
`define RDI_HP_IGN_BIT      2
`define RDI_AUX_DIS_BIT     1

// strap capture waits for the pin synchronisers to fill
`define RDI_STRAP_LOAD_AT   2'h2
`define RDI_STRAP_DONE      2'h3

`endif

// File: design/rdi_pkg.sv
// types of the redriver config slave
package rdi_pkg;

   typedef logic [7:0] rdi_byte_t;
   typedef logic [4:0] rdi_ptr_t;

   typedef enum logic [7:0] {
      st_idle     = 8'h01,
      st_addr     = 8'h02,
      st_addr_ack = 8'h04,
      st_wr_data  = 8'h08,
      st_wr_ack   = 8'h10,
      st_rd_data  = 8'h20,
      st_rd_ack   = 8'h40,
      st_ignore   = 8'h80
   } rdi_state_t;

endpackage : rdi_pkg

// File: design/rdi_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module rdi_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             arst_n,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : rdi_sync

// File: design/rdi_link_rx.sv
// link side bit sampler clocked by the serial bus clock
`timescale 1ns/10ps
module rdi_link_rx (
   // link clock and reset
   input  wire logic link_clock,
   input  wire logic arst_n,
   // serial data pin
   input  wire logic sda_in,
   // sampled bit towards the system clock
   output logic      bit_value,
   output logic      bit_toggle
);

   // each rising edge samples the data line and flags it by a toggle
   always_ff @(posedge link_clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_value  <= 1'b0;
         bit_toggle <= 1'b0;
      end
      else
      begin
         bit_value  <= sda_in;
         bit_toggle <= ~bit_toggle;
      end
   end

endmodule : rdi_link_rx

// File: design/rdi_i2c_config_slave.sv
// two-wire configuration slave of the redriver
//
// Notes on behaviour
// - address is fixed upper nibble plus three strap bits; eighth bit selects read.
// - slave only, 7-bit addressing, works at bus clocks up to 1 MHz.
// - data bytes are eight bits, most significant bit first, both directions.
// - the clock line is never held low by this slave.
// - several bytes may be written or read in one addressed transfer.
// - write enable low makes every byte read-only; high allows config writes.
// - nonexistent locations read all ones and ignore writes.
// - the matching address byte and every written byte are acknowledged by holding data low over the ack clock.
// - start is data falling with clock high; stop is data rising with clock high.
// - after start the first byte is compared; only a match joins the transfer.
// - read-only byte count reports 32 bytes.
// - mode byte bits 7:4 lane mode; top bit resets zero, rest strapped.
// - mode byte bit 2 disables far termination detect; loads inverted detect strap.
// - power-down byte bits 7:4 force lanes down; latched from enable pin.
// - power-down byte bit 1 picks hot-plug polarity: 0 high, 1 low.
// - lane bytes hold equalizer 7:4, flat gain 3:2, swing 1:0, all strapped.
// - threshold byte bits 7:6 pick detector threshold 50/65/80/95 mV, reset 01.
// - threshold byte bit 2 set ignores the hot-plug pin; resets to zero.
// - threshold byte bit 1 set disables the auxiliary mux; resets to zero.
// - swing code picks 900/1000/1100/1200 mV, default 11.
`timescale 1ns/10ps
`include "rdi_cfg.svh"
module rdi_i2c_config_slave
   import rdi_pkg::*;
#(
   parameter rdi_byte_t REV_VENDOR_ID  = 8'h5a, // arbitrary value
   parameter rdi_byte_t DEVICE_TYPE_ID = 8'ha5  // arbitrary value
) (
   // system clock and reset
   input  wire logic            clock,
   input  wire logic            arst_n,
   // serial bus pins
   input  wire logic            scl_in,
   output logic                 scl_out,
   output logic                 scl_oe,
   input  wire logic            sda_in,
   output logic                 sda_out,
   output logic                 sda_oe,
   // strap and control pins
   input  wire logic            address_strap_bit0,
   input  wire logic            address_strap_bit1,
   input  wire logic            address_strap_bit2,
   input  wire logic [2:0]      mode_strap,
   input  wire logic            far_termination_detect_strap,
   input  wire logic            enable_strap,
   input  wire logic [3:0]      equalizer_strap,
   input  wire logic [1:0]      flat_gain_strap,
   input  wire logic [1:0]      output_swing_strap,
   input  wire logic            serial_write_enable,
   input  wire logic            hotplug_input,
   // mode and power controls
   output logic [3:0]           lane_mode_select,
   output logic                 far_termination_detect_disable,
   output logic                 lane_a_receive_power_down,
   output logic                 lane_a_transmit_power_down,
   output logic                 lane_b_transmit_power_down,
   output logic                 lane_b_receive_power_down,
   output logic                 hotplug_polarity_select,
   output logic                 hotplug_active,
   // lane analog settings, index 0..3 = bytes 5..8
   output logic [3:0][3:0]      equalizer_code,
   output logic [3:0][1:0]      flat_gain_code,
   output logic [3:0][1:0]      output_swing_code,
   // feature and threshold controls
   output rdi_byte_t            connector_pair_b_feature,
   output rdi_byte_t            connector_pair_a_feature,
   output logic [1:0]           signal_detect_threshold,
   output logic                 hotplug_pin_ignore,
   output logic                 aux_mux_disable
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [20:0] pin_raw;
   logic [20:0] pin_s;
   logic        scl_s;
   logic        sda_s;
   logic        scl_q;
   logic        sda_q;
   logic        tgl_s;
   logic        tgl_q;
   logic        bit_val;
   logic        bit_tgl;
   logic [2:0]  addr_strap_s;
   logic [2:0]  mode_strap_s;
   logic        det_strap_s;
   logic        en_strap_s;
   logic [3:0]  eq_strap_s;
   logic [1:0]  fg_strap_s;
   logic [1:0]  sw_strap_s;
   logic        wr_en_s;
   logic        hp_s;
   logic        start_ev;
   logic        stop_ev;
   logic        scl_fall;
   logic        bit_ev;
   logic        addr_hit;
   logic        strap_load;
   logic        commit;
   logic [1:0]  init_cnt;
   logic [3:0]  bit_cnt;
   logic        rw;
   rdi_state_t  st;
   rdi_byte_t   rx_byte;
   rdi_byte_t   tx_byte;
   rdi_ptr_t    ptr;
   rdi_byte_t   cfg_byte [3:12];

   ////////////////////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic writable(input rdi_ptr_t p);
      writable = (p >= `RDI_OFS_MODE && p <= `RDI_OFS_LANE_LAST) ||
                 (p >= `RDI_OFS_PAIR_B_FEAT && p <= `RDI_OFS_THRESHOLD);
   endfunction : writable

   function automatic rdi_byte_t read_byte(input rdi_ptr_t p);
      case (p)
         `RDI_OFS_REV_VENDOR : read_byte = REV_VENDOR_ID;
         `RDI_OFS_DEVICE_ID  : read_byte = DEVICE_TYPE_ID;
         `RDI_OFS_BYTE_COUNT : read_byte = `RDI_RST_BYTE_COUNT;
         default:
         begin
            if (p >= `RDI_OFS_MODE && p <= `RDI_OFS_LAST)
               read_byte = cfg_byte[p];
            else
               read_byte = `RDI_DUMMY_BYTE;
         end
      endcase
   endfunction : read_byte

   function automatic rdi_byte_t reset_byte(input int i);
      case (i)
         3       : reset_byte = `RDI_RST_MODE;
         4       : reset_byte = `RDI_RST_POWER_DOWN;
         9       : reset_byte = `RDI_RST_RSVD_NINE;
         10, 11  : reset_byte = `RDI_RST_FEATURE;
         12      : reset_byte = `RDI_RST_THRESHOLD;
         default : reset_byte = `RDI_RST_LANE;
      endcase
   endfunction : reset_byte

   ////////////////////////////////////////////////////////////////////////////////////////
   // pins, link sampler and synchronisers

   assign scl_out = 1'b0;
   assign scl_oe  = 1'b0;
   assign sda_out = 1'b0;

   rdi_link_rx u_link (
      .link_clock (scl_in),
      .arst_n     (arst_n),
      .sda_in     (sda_in),
      .bit_value  (bit_val),
      .bit_toggle (bit_tgl)
   );

   assign pin_raw = {bit_tgl, hotplug_input, serial_write_enable, output_swing_strap,
                     flat_gain_strap, equalizer_strap, enable_strap,
                     far_termination_detect_strap, mode_strap, address_strap_bit2,
                     address_strap_bit1, address_strap_bit0, sda_in, scl_in};

   rdi_sync #(.WIDTH(21)) u_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .d      (pin_raw),
      .q      (pin_s)
   );

   assign scl_s        = pin_s[0];
   assign sda_s        = pin_s[1];
   assign addr_strap_s = pin_s[4:2];
   assign mode_strap_s = pin_s[7:5];
   assign det_strap_s  = pin_s[8];
   assign en_strap_s   = pin_s[9];
   assign eq_strap_s   = pin_s[13:10];
   assign fg_strap_s   = pin_s[15:14];
   assign sw_strap_s   = pin_s[17:16];
   assign wr_en_s      = pin_s[18];
   assign hp_s         = pin_s[19];
   assign tgl_s        = pin_s[20];

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // same level as the synchroniser reset, so no false edge after reset
         scl_q <= 1'b0;
         sda_q <= 1'b0;
         tgl_q <= 1'b0;
      end
      else
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         tgl_q <= tgl_s;
      end
   end

   assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
   assign scl_fall = scl_q & ~scl_s;
   assign bit_ev   = tgl_s ^ tgl_q;
   assign addr_hit = rx_byte[6:0] == {`RDI_ADDR_FIXED, addr_strap_s};
   assign commit   = bit_ev && st == st_wr_ack && wr_en_s && writable(ptr);

   ////////////////////////////////////////////////////////////////////////////////////////
   // protocol state machine

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st      <= st_idle;
         bit_cnt <= 4'h0;
         rx_byte <= 8'h00;
         tx_byte <= 8'h00;
         ptr     <= 5'h00;
         rw      <= 1'b0;
      end
      else if (start_ev)
      begin
         st      <= st_addr;
         bit_cnt <= 4'h0;
         ptr     <= 5'h00;
      end
      else if (stop_ev)
         st <= st_idle;
      else if (bit_ev)
      begin
         case (st)
            st_addr:
            begin
               rx_byte <= {rx_byte[6:0], bit_val};
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'h7)
               begin
                  bit_cnt <= 4'h0;
                  rw      <= bit_val;
                  st      <= addr_hit ? st_addr_ack : st_ignore;
               end
            end
            st_addr_ack:
            begin
               if (rw)
               begin
                  tx_byte <= read_byte(ptr);
                  st      <= st_rd_data;
               end
               else
                  st <= st_wr_data;
            end
            st_wr_data:
            begin
               rx_byte <= {rx_byte[6:0], bit_val};
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'h7)
               begin
                  bit_cnt <= 4'h0;
                  st      <= st_wr_ack;
               end
            end
            st_wr_ack:
            begin
               ptr <= 5'(ptr + 5'h01);
               st  <= st_wr_data;
            end
            st_rd_data:
            begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'h7)
               begin
                  bit_cnt <= 4'h0;
                  st      <= st_rd_ack;
               end
            end
            st_rd_ack:
            begin
               if (!bit_val)
               begin
                  ptr     <= 5'(ptr + 5'h01);
                  tx_byte <= read_byte(5'(ptr + 5'h01));
                  st      <= st_rd_data;
               end
               else
                  st <= st_ignore;
            end
            st_idle, st_ignore:
               st <= st;
            default:
               st <= st_idle;
         endcase
      end
      else if (scl_fall && st == st_rd_data)
         tx_byte <= {tx_byte[6:0], 1'b0};
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // data line drive, changed while the clock is low and released at start or stop

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         sda_oe <= 1'b0;
      else if (start_ev || stop_ev)
         sda_oe <= 1'b0;
      else if (scl_fall)
      begin
         case (st)
            st_addr_ack, st_wr_ack : sda_oe <= 1'b1;
            st_rd_data             : sda_oe <= ~tx_byte[7];
            default                : sda_oe <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // configuration bytes

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         init_cnt <= 2'h0;
      else if (init_cnt != `RDI_STRAP_DONE)
         init_cnt <= init_cnt + 2'h1;
   end

   assign strap_load = init_cnt == `RDI_STRAP_LOAD_AT;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 3; i <= 12; i++)
            cfg_byte[i] <= reset_byte(i);
      end
      else if (strap_load)
      begin
         cfg_byte[3] <= {1'b0, mode_strap_s, 1'b0, ~det_strap_s, 2'b00};
         cfg_byte[4] <= {{4{~en_strap_s}}, `RDI_PD_LOW_BITS};
         for (int i = 5; i <= 8; i++)
            cfg_byte[i] <= {eq_strap_s, fg_strap_s, sw_strap_s};
      end
      else if (commit)
         cfg_byte[ptr] <= rx_byte;
   end

   // hot-plug qualification
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         hotplug_active <= 1'b0;
      else
         hotplug_active <= hotplug_pin_ignore | (hp_s ^ hotplug_polarity_select);
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // control outputs

   assign lane_mode_select               = cfg_byte[3][`RDI_MODE_SEL_HI:`RDI_MODE_SEL_LO];
   assign far_termination_detect_disable = cfg_byte[3][`RDI_DET_DIS_BIT];
   assign lane_a_receive_power_down      = cfg_byte[4][`RDI_PD_LANE_A_RX];
   assign lane_a_transmit_power_down     = cfg_byte[4][`RDI_PD_LANE_A_TX];
   assign lane_b_transmit_power_down     = cfg_byte[4][`RDI_PD_LANE_B_TX];
   assign lane_b_receive_power_down      = cfg_byte[4][`RDI_PD_LANE_B_RX];
   assign hotplug_polarity_select        = cfg_byte[4][`RDI_HP_POL_BIT];
   assign connector_pair_b_feature       = cfg_byte[10];
   assign connector_pair_a_feature       = cfg_byte[11];
   assign signal_detect_threshold        = cfg_byte[12][`RDI_VTH_HI:`RDI_VTH_LO];
   assign hotplug_pin_ignore             = cfg_byte[12][`RDI_HP_IGN_BIT];
   assign aux_mux_disable                = cfg_byte[12][`RDI_AUX_DIS_BIT];

   for (genvar g = 0; g < 4; g++)
   begin : g_lane
      assign equalizer_code[g]    = cfg_byte[5+g][`RDI_EQ_HI:`RDI_EQ_LO];
      assign flat_gain_code[g]    = cfg_byte[5+g][`RDI_FG_HI:`RDI_FG_LO];
      assign output_swing_code[g] = cfg_byte[5+g][`RDI_SW_HI:`RDI_SW_LO];
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   a_addr_miss: assert property (st == st_addr && bit_ev && bit_cnt == 4'h7 && !addr_hit
      && !start_ev && !stop_ev |=> st == st_ignore) else $error("address miss joined");
   a_ack_drive: assert property ((st == st_addr_ack || st == st_wr_ack) && scl_fall
      && !start_ev && !stop_ev |=> sda_oe) else $error("no ack drive");
   a_ack_hold: assert property (st == st_wr_ack && sda_oe && !scl_fall && !start_ev
      && !stop_ev |=> sda_oe) else $error("ack released early");
   a_locked_write: assert property (bit_ev && st == st_wr_ack && !wr_en_s
      |=> $stable(lane_mode_select) && $stable(connector_pair_a_feature))
      else $error("write while locked");
   a_write_commit: assert property (commit && ptr == `RDI_OFS_MODE
      |=> cfg_byte[3] == $past(rx_byte)) else $error("write lost");
   a_ptr_step: assert property (bit_ev && st == st_wr_ack && !start_ev && !stop_ev
      |=> ptr == 5'($past(ptr) + 5'h01)) else $error("pointer not advanced");
   a_start_state: assert property (start_ev |=> st == st_addr && ptr == 5'h00
      && !sda_oe) else $error("start not taken");
   a_stop_state: assert property (stop_ev |=> st == st_idle && !sda_oe)
      else $error("stop not taken");
   a_dummy_read: assert property (bit_ev && st == st_rd_ack && !bit_val
      && ptr == `RDI_OFS_LAST && !start_ev && !stop_ev |=> tx_byte == `RDI_DUMMY_BYTE)
      else $error("dummy byte wrong");
   a_msb_first: assert property (st == st_rd_data && scl_fall && !bit_ev
      && !start_ev && !stop_ev |=> sda_oe == !$past(tx_byte[7])) else $error("bit order");
   a_strap_mode: assert property (strap_load |=> lane_mode_select
      == {1'b0, $past(mode_strap_s)}) else $error("mode strap not latched");

   c_write: cover property (commit);
   c_read_nack: cover property (st == st_rd_ack && bit_ev && bit_val);
   c_ignore: cover property (st == st_ignore);
   c_read_more: cover property (st == st_rd_ack && bit_ev && !bit_val);

endmodule : rdi_i2c_config_slave

// File: test/rdi_bus_master.sv
// two-wire bus master model for the config slave
`timescale 1ns/10ps
module rdi_bus_master #(
   parameter int Q = 320
) (
   // open-drain pulls, high pulls the line low
   output logic      scl_low,
   output logic      sda_low,
   // resolved data line
   input  wire logic sda_line
);
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // bus clock period 4Q, below 1 MHz
   task start_cond();
      sda_low = 1'b1;
      #Q;
      scl_low = 1'b1;
      #Q;
   endtask : start_cond
   task stop_cond();
      sda_low = 1'b1;
      #Q;
      scl_low = 1'b0;
      #Q;
      sda_low = 1'b0;
      #Q;
   endtask : stop_cond
   // data set while clock low, sampled mid-high
   task clk_bit(input logic b, output logic r);
      sda_low = ~b;
      #Q;
      scl_low = 1'b0;
      #Q;
      r = sda_line;
      #Q;
      scl_low = 1'b1;
      #Q;
   endtask : clk_bit
   // eight bits msb first, then the ack clock driving a
   task byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
      for (int i = 7; i >= 0; i--)
         clk_bit(d[i], q[i]);
      clk_bit(a, r);
   endtask : byte_io
endmodule : rdi_bus_master

// File: test/rdi_i2c_config_slave_test.sv
// self-checking bench of the redriver config slave
`timescale 1ns/10ps
`include "rdi_cfg.svh"
module rdi_i2c_config_slave_test
   import rdi_pkg::*;
;
   localparam rdi_byte_t  ID0   = 8'h3c; // arbitrary value
   localparam rdi_byte_t  ID1   = 8'hc3; // arbitrary value
   localparam logic [2:0] STRAP = 3'h5;
   logic            clock, arst_n, serial_write_enable, hotplug_input, scl_low, sda_low;
   logic            scl_line, sda_line, scl_out, scl_oe, sda_out, sda_oe, hotplug_active;
   logic            far_termination_detect_strap, enable_strap, far_termination_detect_disable;
   logic            lane_a_receive_power_down, lane_a_transmit_power_down;
   logic            lane_b_transmit_power_down, lane_b_receive_power_down;
   logic            hotplug_polarity_select, hotplug_pin_ignore, aux_mux_disable;
   logic [2:0]      mode_strap;
   logic [3:0]      equalizer_strap, lane_mode_select;
   logic [1:0]      flat_gain_strap, output_swing_strap, signal_detect_threshold;
   logic [3:0][3:0] equalizer_code;
   logic [3:0][1:0] flat_gain_code, output_swing_code;
   rdi_byte_t       connector_pair_b_feature, connector_pair_a_feature;
   rdi_byte_t       wbuf [14];
   rdi_byte_t       rbuf [14];
   rdi_byte_t       ref_bytes [14];
   int              err_total, check_count;

   assign scl_line = ~(scl_low | (scl_oe & ~scl_out));
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

   rdi_bus_master u_rdi_bus_master (.scl_low, .sda_low, .sda_line);
   rdi_i2c_config_slave #(.REV_VENDOR_ID(ID0), .DEVICE_TYPE_ID(ID1)) u_rdi_i2c_config_slave (
      .clock, .arst_n, .scl_in(scl_line), .scl_out, .scl_oe, .sda_in(sda_line), .sda_out,
      .sda_oe, .address_strap_bit0(STRAP[0]), .address_strap_bit1(STRAP[1]),
      .address_strap_bit2(STRAP[2]), .mode_strap, .far_termination_detect_strap,
      .enable_strap, .equalizer_strap, .flat_gain_strap, .output_swing_strap,
      .serial_write_enable, .hotplug_input, .lane_mode_select, .far_termination_detect_disable,
      .lane_a_receive_power_down, .lane_a_transmit_power_down, .lane_b_transmit_power_down,
      .lane_b_receive_power_down, .hotplug_polarity_select, .hotplug_active, .equalizer_code,
      .flat_gain_code, .output_swing_code, .connector_pair_b_feature,
      .connector_pair_a_feature, .signal_detect_threshold, .hotplug_pin_ignore,
      .aux_mux_disable);

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] want);
      check_count++;
      if (got !== want)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : chk
   // addressed transfer of n bytes from offset 0, closed by a stop
   task txn(input logic rw, input int n);
      logic [7:0] q;
      logic       r;
      u_rdi_bus_master.start_cond();
      u_rdi_bus_master.byte_io({`RDI_ADDR_FIXED, STRAP, rw}, 1'b1, q, r);
      chk({7'h0, r}, 8'h00);
      for (int i = 0; i < n; i++)
      begin
         u_rdi_bus_master.byte_io(rw ? 8'hff : wbuf[i], rw ? (i == n - 1) : 1'b1, rbuf[i], r);
         if (!rw)
            chk({7'h0, r}, 8'h00);
      end
      u_rdi_bus_master.stop_cond();
   endtask : txn
   task read_cmp();
      txn(1'b1, 14);
      for (int i = 0; i < 14; i++)
         chk(rbuf[i], ref_bytes[i]);
   endtask : read_cmp
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset();
      ref_bytes = '{ID0, ID1, `RDI_RST_BYTE_COUNT, 8'h54, 8'h0d, 8'ha7, 8'ha7, 8'ha7, 8'ha7,
         `RDI_RST_RSVD_NINE, `RDI_RST_FEATURE, `RDI_RST_FEATURE, 8'h58, `RDI_DUMMY_BYTE};
      read_cmp();
      chk({lane_mode_select, 3'h0, far_termination_detect_disable}, 8'h51);
      chk({signal_detect_threshold, 4'h0, output_swing_code[3]}, 8'h43);
      chk({7'h0, scl_oe}, 8'h00);
      chk({7'h0, hotplug_active}, 8'h00);
      hotplug_input = 1'b1;
      repeat (4) @(negedge clock);
      chk({7'h0, hotplug_active}, 8'h01);
   endtask : t_reset
   task t_locked();
      wbuf = '{default: 8'h00};
      txn(1'b0, 14);
      read_cmp();
   endtask : t_locked
   task t_write();
      wbuf = '{8'h11, 8'h22, 8'h33, 8'hf4, 8'hff, 8'h5b, 8'h6c, 8'h7d, 8'h8e, 8'h99, 8'h12,
         8'h34, 8'h9e, 8'h00};
      ref_bytes = '{ID0, ID1, 8'h20, 8'hf4, 8'hff, 8'h5b, 8'h6c, 8'h7d, 8'h8e, 8'h60, 8'h12,
         8'h34, 8'h9e, 8'hff};
      @(negedge clock);
      serial_write_enable = 1'b1;
      repeat (4) @(negedge clock);
      txn(1'b0, 14);
      read_cmp();
      chk({lane_mode_select, 3'h0, far_termination_detect_disable}, 8'hf1);
      chk({lane_a_receive_power_down, lane_a_transmit_power_down, lane_b_transmit_power_down,
         lane_b_receive_power_down, 3'h0, hotplug_polarity_select}, 8'hf1);
      chk({equalizer_code[1], flat_gain_code[2], output_swing_code[3]}, 8'h6e);
      chk({signal_detect_threshold, 3'h0, hotplug_pin_ignore, aux_mux_disable,
         hotplug_active}, 8'h87);
      chk(connector_pair_a_feature, 8'h34);
      chk(connector_pair_b_feature, 8'h12);
   endtask : t_write
   task t_abort();
      logic [7:0] q;
      logic       r;
      u_rdi_bus_master.start_cond();
      u_rdi_bus_master.byte_io({`RDI_ADDR_FIXED, STRAP, 1'b0}, 1'b1, q, r);
      for (int i = 0; i < 3; i++)
         u_rdi_bus_master.byte_io(8'h00, 1'b1, q, r);
      for (int i = 0; i < 4; i++)
         u_rdi_bus_master.clk_bit(1'b0, r);
      u_rdi_bus_master.stop_cond();
      read_cmp();
   endtask : t_abort
   task t_mismatch();
      logic [7:0] q;
      logic       r;
      u_rdi_bus_master.start_cond();
      u_rdi_bus_master.byte_io({`RDI_ADDR_FIXED, ~STRAP, 1'b1}, 1'b1, q, r);
      chk({7'h0, r}, 8'h01);
      u_rdi_bus_master.byte_io(8'hff, 1'b1, q, r);
      chk(q, 8'hff);
      u_rdi_bus_master.stop_cond();
   endtask : t_mismatch
   task conclude();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      arst_n = 1'b0;
      serial_write_enable = 1'b0;
      hotplug_input = 1'b0;
      mode_strap = 3'h5;
      far_termination_detect_strap = 1'b0;
      enable_strap = 1'b1;
      equalizer_strap = 4'ha;
      flat_gain_strap = 2'h1;
      output_swing_strap = 2'h3;
      err_total = 0;
      check_count = 0;
      repeat (8) @(negedge clock);
      arst_n = 1'b1;
      repeat (6) @(negedge clock);
      t_reset();
      t_locked();
      t_write();
      t_abort();
      t_mismatch();
      conclude();
   end
   initial
   begin
      #1_900_000;
      err_total++;
      conclude();
   end
endmodule : rdi_i2c_config_slave_test
